// >>> rtl/fetch_sequencer.sv
// fetch_sequencer: instruction sequencing, program counter and program memory addressing.
// assumes program memory answers one core_clk after its address; all inputs synchronous.
`timescale 1ns/1ns
`default_nettype none
module fetch_sequencer
    import fetch_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic            master_clear_n,
    // program memory
    output logic [PMEM_AW-1:0]   pmem_addr_r,
    input  wire logic [INSN_W-1:0] pmem_data,
    // execution side
    input  wire branch_req_t     branch_req,
    input  wire logic            irq_req,
    output logic                 irq_ack_r,
    output logic [PC_W-1:0]      return_pc_r,
    output insn_t                ir_r,
    output exec_strobe_t         strobe_r,
    output phase_t               phase_r,
    output logic [PC_W-1:0]      pc_r,
    output logic                 cal_fetch_err_r,
    // calibration readout
    input  wire logic            cal_req,
    input  wire logic [2:0]      cal_sel,
    output logic                 cal_busy_r,
    output logic                 cal_valid_r,
    output logic [31:0]          cal_word_r,
    // oscillator pins
    input  wire logic            crystal_osc_mode,
    input  wire logic            clock_in_pushbutton,
    input  wire logic            gpo_value,
    output logic                 pushbutton_pullup_en_r,
    output logic                 pushbutton_irq_r,
    output logic                 clock_out_gpo_r
);

    logic             rst;
    logic [PC_W-1:0]  fetch_pc_r;
    insn_t            fetch_r;
    logic             flush_r;
    logic             pb_prev_r;
    cal_state_t       cal_state_r;
    logic [1:0]       cal_cnt_r;
    logic [PMEM_AW-1:0] cal_addr_r;
    logic             redirect;
    logic [PC_W-1:0]  redirect_pc;

    assign rst = sys_rst | ~master_clear_n;

    ////////////////////////////////////////////////////////////////////////
    // phases
    phase_gen u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .phase_r  (phase_r)
    );

    ////////////////////////////////////////////////////////////////////////
    // program counter; branches win over interrupts, interrupt held off until then
    assign redirect    = (phase_r == PHASE_FOUR) & (branch_req.take | irq_req);
    assign redirect_pc = branch_req.take ? branch_req.target : INT_VECTOR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_r       <= RESET_VECTOR;
            fetch_pc_r <= RESET_VECTOR;
        end else if (phase_r == PHASE_ONE) begin
            fetch_pc_r <= pc_r;
            pc_r       <= pc_r + PC_STEP;
        end else if (redirect) begin
            pc_r       <= redirect_pc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_ack_r   <= 1'b0;
            return_pc_r <= RESET_VECTOR;
        end else begin
            irq_ack_r <= (phase_r == PHASE_FOUR) & irq_req & ~branch_req.take;
            if ((phase_r == PHASE_FOUR) & irq_req & ~branch_req.take) begin
                return_pc_r <= pc_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory address: fetch in phase three, calibration byte in phase one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmem_addr_r <= RESET_VECTOR[PMEM_AW-1:0];
        end else if (phase_r == PHASE_TWO) begin
            pmem_addr_r <= fetch_pc_r[PMEM_AW-1:0];
        end else if ((phase_r == PHASE_FOUR) & (cal_state_r == CAL_ADDR)) begin
            pmem_addr_r <= cal_addr_r;
        end
    end

    // code landing in the calibration area is flagged, not stopped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cal_fetch_err_r <= 1'b0;
        end else if (phase_r == PHASE_TWO) begin
            cal_fetch_err_r <= fetch_pc_r[PMEM_AW-1:0] >= CAL_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch capture and flush
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flush_r <= 1'b0;
        end else if (phase_r == PHASE_ONE) begin
            flush_r <= 1'b0;
        end else if (redirect) begin
            flush_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_r <= '{valid: 1'b0, word: NOP_WORD};
        end else if (phase_r == PHASE_FOUR) begin
            // word fetched under a redirect is dropped in the same edge
            fetch_r.word  <= pmem_data;
            fetch_r.valid <= ~(flush_r | redirect);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ir_r <= '{valid: 1'b0, word: NOP_WORD};
        end else if (phase_r == PHASE_ONE) begin
            ir_r <= fetch_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // execution strobes, registered one edge ahead of their phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobe_r <= '{decode: 1'b0, opnd_rd: 1'b0, dest_wr: 1'b0};
        end else begin
            unique case (phase_r)
                PHASE_ONE: begin
                    strobe_r.decode  <= fetch_r.valid;
                    strobe_r.opnd_rd <= fetch_r.valid;
                    strobe_r.dest_wr <= 1'b0;
                end
                PHASE_TWO: begin
                    strobe_r.decode  <= ir_r.valid;
                    strobe_r.opnd_rd <= 1'b0;
                    strobe_r.dest_wr <= 1'b0;
                end
                PHASE_THREE: begin
                    strobe_r.decode  <= ir_r.valid;
                    strobe_r.opnd_rd <= 1'b0;
                    strobe_r.dest_wr <= ir_r.valid;
                end
                PHASE_FOUR: begin
                    strobe_r.decode  <= 1'b0;
                    strobe_r.opnd_rd <= 1'b0;
                    strobe_r.dest_wr <= 1'b0;
                end
                default: begin
                    strobe_r <= '{decode: 1'b0, opnd_rd: 1'b0, dest_wr: 1'b0};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration readout: one byte per four-phase round, exponent first, high to low mantissa
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cal_state_r <= CAL_IDLE;
            cal_cnt_r   <= CAL_FIRST_BYTE;
            cal_addr_r  <= CAL_BASE;
            cal_busy_r  <= 1'b0;
            cal_valid_r <= 1'b0;
            cal_word_r  <= 32'h0000_0000;
        end else begin
            cal_valid_r <= 1'b0;
            unique case (cal_state_r)
                CAL_IDLE: begin
                    if (cal_req) begin
                        cal_busy_r  <= 1'b1;
                        cal_cnt_r   <= CAL_FIRST_BYTE;
                        cal_word_r  <= 32'h0000_0000;
                        cal_state_r <= CAL_ADDR;
                        if (cal_sel == CAL_OSC_MULT) begin
                            cal_addr_r <= CAL_OSC;
                            cal_cnt_r  <= CAL_LAST_BYTE;
                        end else if (cal_sel == CAL_WATCHDOG_TIMEOUT) begin
                            cal_addr_r <= CAL_WDT;
                            cal_cnt_r  <= CAL_LAST_BYTE;
                        end else begin
                            cal_addr_r <= CAL_BASE + {8'h00, cal_sel[1:0], 2'b00};
                        end
                    end
                end
                CAL_ADDR: begin
                    if (phase_r == PHASE_FOUR) begin
                        cal_state_r <= CAL_DATA;
                    end
                end
                CAL_DATA: begin
                    if (phase_r == PHASE_TWO) begin
                        cal_word_r <= {cal_word_r[23:0], pmem_data[BYTE_W-1:0]};
                        cal_addr_r <= cal_addr_r + 12'h001;
                        cal_cnt_r  <= cal_cnt_r + 2'h1;
                        if (cal_cnt_r == CAL_LAST_BYTE) begin
                            cal_state_r <= CAL_IDLE;
                            cal_busy_r  <= 1'b0;
                            cal_valid_r <= 1'b1;
                        end else begin
                            cal_state_r <= CAL_ADDR;
                        end
                    end
                end
                default: begin
                    cal_state_r <= CAL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator pins; the crystal amplifier itself is analog and lives outside
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pb_prev_r              <= 1'b1;
            pushbutton_irq_r       <= 1'b0;
            pushbutton_pullup_en_r <= 1'b0;
            clock_out_gpo_r        <= 1'b0;
        end else begin
            pb_prev_r              <= clock_in_pushbutton;
            pushbutton_pullup_en_r <= ~crystal_osc_mode;
            // falling edge = button press against the pull-up
            pushbutton_irq_r <= ~crystal_osc_mode & pb_prev_r & ~clock_in_pushbutton;
            if (crystal_osc_mode) begin
                clock_out_gpo_r <= (phase_r == PHASE_TWO) | (phase_r == PHASE_THREE);
            end else begin
                clock_out_gpo_r <= gpo_value;
            end
        end
    end

endmodule : fetch_sequencer
`default_nettype wire

// >>> rtl/fetch_pkg.sv
// fetch_pkg: constants, types and carriers for the fetch/sequencing block.
// assumes a single core_clk domain; program memory returns data one cycle after address.
package fetch_pkg;

    localparam int PC_W        = 13;
    localparam int PMEM_AW     = 12;
    localparam int INSN_W      = 14;
    localparam int BYTE_W      = 8;

    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR   = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP      = 13'h0001;

    // program memory map
    localparam logic [PMEM_AW-1:0] PAGE0_FIRST = 12'h005;
    localparam logic [PMEM_AW-1:0] PAGE0_LAST  = 12'h7FF;
    localparam logic [PMEM_AW-1:0] PAGE1_FIRST = 12'h800;
    localparam logic [PMEM_AW-1:0] PAGE1_LAST  = 12'hFBF;
    localparam logic [PMEM_AW-1:0] CAL_BASE    = 12'hFC0;
    localparam logic [PMEM_AW-1:0] CAL_OSC     = 12'hFD0;
    localparam logic [PMEM_AW-1:0] CAL_WDT     = 12'hFD2;
    localparam logic [PMEM_AW-1:0] CAL_CSUM    = 12'hFF9;

    // calibration constant selectors: four-word float groups for 0 to 3, single words for 4 and 5
    localparam logic [2:0] CAL_SLOPE_REF_RATIO     = 3'h0;
    localparam logic [2:0] CAL_BANDGAP_VOLT_CONST  = 3'h1;
    localparam logic [2:0] CAL_TEMP_SENSOR_VOLT    = 3'h2;
    localparam logic [2:0] CAL_TEMP_COEFF_CONST    = 3'h3;
    localparam logic [2:0] CAL_OSC_MULT            = 3'h4;
    localparam logic [2:0] CAL_WATCHDOG_TIMEOUT    = 3'h5;
    localparam logic [1:0] CAL_LAST_BYTE           = 2'h3;
    localparam logic [1:0] CAL_FIRST_BYTE          = 2'h0;

    localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;

    typedef enum logic [3:0] {
        PHASE_ONE   = 4'b0001,
        PHASE_TWO   = 4'b0010,
        PHASE_THREE = 4'b0100,
        PHASE_FOUR  = 4'b1000
    } phase_t;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_ADDR = 3'b010,
        CAL_DATA = 3'b100
    } cal_state_t;

    typedef struct packed {
        logic              valid;
        logic [INSN_W-1:0] word;
    } insn_t;

    typedef struct packed {
        logic            take;
        logic [PC_W-1:0] target;
    } branch_req_t;

    typedef struct packed {
        logic decode;
        logic opnd_rd;
        logic dest_wr;
    } exec_strobe_t;

endpackage : fetch_pkg

// >>> rtl/phase_gen.sv
// phase_gen: divides the core clock by four into one-hot phases.
// assumes a synchronous active-high reset already merged with master clear.
`timescale 1ns/1ns
`default_nettype none
module phase_gen
    import fetch_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    output phase_t    phase_r
);

    ////////////////////////////////////////////////////////////////////////
    // rotating one-hot: exactly one phase is ever active, so no overlap
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_r <= PHASE_ONE;
        end else begin
            unique case (phase_r)
                PHASE_ONE:   phase_r <= PHASE_TWO;
                PHASE_TWO:   phase_r <= PHASE_THREE;
                PHASE_THREE: phase_r <= PHASE_FOUR;
                PHASE_FOUR:  phase_r <= PHASE_ONE;
                default:     phase_r <= PHASE_ONE;
            endcase
        end
    end

endmodule : phase_gen
`default_nettype wire

// >>> tb/fetch_props_properties.sv
// fetch_props: timing checks on the fetch sequencer's ports.
// assumes it is bound onto fetch_sequencer; both resets synchronous.
`timescale 1ns/1ns
`default_nettype none
module fetch_props
    import fetch_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               master_clear_n,
    input wire logic [PMEM_AW-1:0] pmem_addr_r,
    input wire branch_req_t        branch_req,
    input wire logic               irq_req,
    input wire logic               irq_ack_r,
    input wire insn_t              ir_r,
    input wire exec_strobe_t       strobe_r,
    input wire phase_t             phase_r,
    input wire logic [PC_W-1:0]    pc_r,
    input wire logic               cal_req,
    input wire logic               cal_busy_r,
    input wire logic               cal_valid_r,
    input wire logic               crystal_osc_mode,
    input wire logic               clock_out_gpo_r,
    input wire logic               pushbutton_pullup_en_r
);
    default clocking cb @(posedge core_clk); endclocking
    // the release edge still resets the design, so checks wait one more edge
    logic in_rst_r;
    always_ff @(posedge core_clk) begin
        in_rst_r <= sys_rst | ~master_clear_n;
    end
    // master clear is a second reset source, so it silences checks too
    default disable iff (sys_rst || !master_clear_n || in_rst_r);
    ////////////////////////////////////////
    AST_PHASE_ADV: assert property (phase_r != PHASE_FOUR |=> phase_r == ($past(phase_r) << 1))
        else $error("phase did not advance");
    AST_PHASE_WRAP: assert property (phase_r == PHASE_FOUR |=> phase_r == PHASE_ONE)
        else $error("phase did not wrap to one");
    AST_PC_STEP: assert property (phase_r == PHASE_ONE |=> pc_r == $past(pc_r) + PC_STEP)
        else $error("counter did not step in phase one");
    AST_ADDR: assert property (phase_r == PHASE_THREE |-> pmem_addr_r == pc_r[11:0] - 12'h001)
        else $error("fetch address not counter modulo 4096");
    AST_BRANCH: assert property (phase_r == PHASE_FOUR && branch_req.take
        |=> pc_r == $past(branch_req.target)) else $error("branch target not loaded");
    AST_IRQ: assert property (phase_r == PHASE_FOUR && irq_req && !branch_req.take
        |=> irq_ack_r && pc_r == INT_VECTOR) else $error("interrupt vector not loaded");
    AST_FLUSH: assert property (phase_r == PHASE_FOUR && branch_req.take |-> ##2 !ir_r.valid)
        else $error("fetched word not flushed");
    AST_EXEC: assert property (phase_r == PHASE_TWO && ir_r.valid
        |-> strobe_r == 3'b110 ##1 strobe_r == 3'b100 ##1 strobe_r == 3'b101)
        else $error("execute strobes out of phase");
    AST_IDLE: assert property ((!ir_r.valid || phase_r == PHASE_ONE) |-> strobe_r == 3'b000)
        else $error("strobe without valid instruction");
    AST_CAL: assert property (cal_req && !cal_busy_r |=> cal_busy_r ##[1:24] cal_valid_r)
        else $error("calibration read did not finish");
    AST_CLKOUT: assert property (crystal_osc_mode && $past(crystal_osc_mode)
        |-> clock_out_gpo_r == (phase_r[2] | phase_r[3])) else $error("clock output wrong");
    AST_PULLUP: assert property (1'b1 |=> pushbutton_pullup_en_r == !$past(crystal_osc_mode))
        else $error("pull-up enable wrong");
    cover property (phase_r == PHASE_FOUR && branch_req.take);
    cover property (irq_ack_r);
    cover property (cal_valid_r);
endmodule : fetch_props
bind fetch_sequencer fetch_props fetch_props_i (.core_clk, .sys_rst, .master_clear_n,
    .pmem_addr_r, .branch_req, .irq_req, .irq_ack_r, .ir_r, .strobe_r, .phase_r, .pc_r,
    .cal_req, .cal_busy_r, .cal_valid_r, .crystal_osc_mode, .clock_out_gpo_r,
    .pushbutton_pullup_en_r);
`default_nettype wire

// >>> tb/pmem_model.sv
// pmem_model: program memory answering one cycle after the address.
// word at address a holds {2'b10, a}, so every fetch is traceable.
`timescale 1ns/1ns
`default_nettype none
module pmem_model
    import fetch_pkg::*;
(
    input  wire logic [PMEM_AW-1:0] addr,
    input  wire logic               core_clk,
    output logic [INSN_W-1:0]       data
);
    // only 4096 words exist; calibration low byte equals address
    always_ff @(posedge core_clk) begin
        data <= {2'b10, addr};
    end
endmodule : pmem_model
`default_nettype wire

// >>> tb/testbench.sv
// testbench: directed checks of fetch, branch, interrupt, calibration, pins.
// assumes pmem_model as memory; expected words follow its address pattern.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import fetch_pkg::*;
;
    logic core_clk = 1'b0, sys_rst = 1'b1, master_clear_n = 1'b1;
    logic irq_req = 1'b0, cal_req = 1'b0, crystal_osc_mode = 1'b0;
    logic clock_in_pushbutton = 1'b1, gpo_value = 1'b0;
    logic [2:0] cal_sel = 3'h0;
    branch_req_t branch_req = '0;
    logic [PMEM_AW-1:0] pmem_addr_r;
    logic [INSN_W-1:0] pmem_data;
    logic [PC_W-1:0] pc_r, return_pc_r;
    logic irq_ack_r, cal_busy_r, cal_valid_r, pushbutton_pullup_en_r;
    logic pushbutton_irq_r, clock_out_gpo_r, cal_fetch_err_r;
    logic [31:0] cal_word_r;
    insn_t ir_r;
    exec_strobe_t strobe_r;
    phase_t phase_r;
    int fails = 0, check_count = 0;
    fetch_sequencer fetch_sequencer_i (.core_clk, .sys_rst, .master_clear_n, .pmem_addr_r,
        .pmem_data, .branch_req, .irq_req, .irq_ack_r, .return_pc_r, .ir_r, .strobe_r,
        .phase_r, .pc_r, .cal_fetch_err_r, .cal_req, .cal_sel, .cal_busy_r, .cal_valid_r,
        .cal_word_r, .crystal_osc_mode, .clock_in_pushbutton, .gpo_value,
        .pushbutton_pullup_en_r, .pushbutton_irq_r, .clock_out_gpo_r);
    pmem_model pmem_model_i (.addr(pmem_addr_r), .core_clk(core_clk), .data(pmem_data));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // bounded: a stuck phase counter must not hang the run
    task automatic step_to(input phase_t p);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (phase_r !== p && n < 8);
        check(phase_r, p);
    endtask : step_to
    task automatic test_pipeline;
        step_to(PHASE_TWO);
        check(ir_r.valid, 1'b0);
        for (int k = 0; k < 4; k++) begin
            step_to(PHASE_TWO);
            check(ir_r, {1'b1, 2'b10, 12'(k)});
            check(pc_r, 13'(k + 2));
            check(strobe_r, 3'b110);
            step_to(PHASE_THREE);
            check(strobe_r, 3'b100);
            step_to(PHASE_FOUR);
            check(strobe_r, 3'b101);
        end
        $display("test pipeline done");
    endtask : test_pipeline
    task automatic test_branch;
        step_to(PHASE_THREE);
        @(posedge core_clk);
        branch_req <= '{take: 1'b1, target: 13'h1805};
        @(posedge core_clk);
        branch_req <= '0;
        step_to(PHASE_TWO);
        check(ir_r.valid, 1'b0);
        step_to(PHASE_TWO);
        check(ir_r, {1'b1, 2'b10, 12'h805});
        check(pc_r, 13'h1807);
        check(cal_fetch_err_r, 1'b0);
        // stray jump into the calibration area must raise the flag
        step_to(PHASE_THREE);
        @(posedge core_clk);
        branch_req <= '{take: 1'b1, target: 13'h1FC0};
        @(posedge core_clk);
        branch_req <= '0;
        step_to(PHASE_THREE);
        check(cal_fetch_err_r, 1'b1);
        $display("test branch done");
    endtask : test_branch
    task automatic test_irq;
        logic [PC_W-1:0] ret;
        step_to(PHASE_THREE);
        ret = pc_r;
        @(posedge core_clk);
        irq_req <= 1'b1;
        @(posedge core_clk);
        irq_req <= 1'b0;
        #1;
        check(irq_ack_r, 1'b1);
        check(pc_r, INT_VECTOR);
        check(return_pc_r, ret);
        step_to(PHASE_TWO);
        check(ir_r.valid, 1'b0);
        step_to(PHASE_TWO);
        check(ir_r, {1'b1, 2'b10, 12'h004});
        $display("test interrupt done");
    endtask : test_irq
    task automatic test_cal;
        logic [7:0] b;
        for (int s = 0; s < 6; s++) begin
            @(posedge core_clk);
            cal_sel <= 3'(s);
            cal_req <= 1'b1;
            @(posedge core_clk);
            cal_req <= 1'b0;
            #1;
            check(cal_busy_r, 1'b1);
            for (int n = 0; n < 30 && cal_valid_r !== 1'b1; n++) begin
                @(posedge core_clk);
                #1;
            end
            check(cal_valid_r, 1'b1);
            check(cal_busy_r, 1'b0);
            b = 8'hC0 + 8'(4 * s);
            if (s < 4) check(cal_word_r, {b, b + 8'h01, b + 8'h02, b + 8'h03});
            else check(cal_word_r, {24'h00_0000, ((s == 4) ? 8'hD0 : 8'hD2)});
        end
        $display("test calibration done");
    endtask : test_cal
    task automatic test_pins(input logic xtal);
        logic hit;
        @(posedge core_clk);
        crystal_osc_mode <= xtal;
        gpo_value <= 1'b1;
        clock_in_pushbutton <= 1'b1;
        repeat (2) @(posedge core_clk);
        clock_in_pushbutton <= 1'b0;
        gpo_value <= 1'b0;
        #1;
        check(pushbutton_pullup_en_r, !xtal);
        if (!xtal) check(clock_out_gpo_r, 1'b1);
        hit = 1'b0;
        repeat (3) begin
            @(posedge core_clk);
            #1;
            hit |= pushbutton_irq_r;
        end
        check(hit, !xtal);
        if (!xtal) check(clock_out_gpo_r, 1'b0);
        $display("test pins done");
    endtask : test_pins
    task automatic test_master_clear_n;
        @(posedge core_clk);
        master_clear_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({pc_r, phase_r, ir_r.valid}, {13'h0000, PHASE_ONE, 1'b0});
        @(posedge core_clk);
        master_clear_n <= 1'b1;
        test_pipeline();
        $display("test master clear done");
    endtask : test_master_clear_n
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // the tests need a few hundred cycles; this is far beyond
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        test_pipeline();
        test_branch();
        test_irq();
        test_cal();
        test_pins(1'b0);
        test_pins(1'b1);
        test_master_clear_n();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
